// ---- pkg/oled_core_pkg.sv ----
// constants and types shared by the display timing core
package oled_core_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned ON_DELAY_MS = 40;
  localparam int unsigned ON_DELAY_CYC = ON_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned RST_MIN_NS = 3000;
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned RST_MIN_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] CMD_CONTRAST = 8'h81;
  localparam logic [7:0] CMD_SEG_NORMAL = 8'hA0;
  localparam logic [7:0] CMD_SEG_REMAP = 8'hA1;
  localparam logic [7:0] CMD_ALL_NORMAL = 8'hA4;
  localparam logic [7:0] CMD_ALL_ON = 8'hA5;
  localparam logic [7:0] CMD_MUX = 8'hA8;
  localparam logic [7:0] CMD_IREF = 8'hAD;
  localparam logic [7:0] CMD_DISP_OFF = 8'hAE;
  localparam logic [7:0] CMD_DISP_ON = 8'hAF;
  localparam logic [7:0] CMD_SCAN_NORMAL = 8'hC0;
  localparam logic [7:0] CMD_SCAN_REMAP = 8'hC8;
  localparam logic [7:0] CMD_START_LINE = 8'hD3;
  localparam logic [7:0] CMD_CLK_DIV = 8'hD5;
  localparam logic [7:0] CMD_PHASE = 8'hD9;
  localparam logic [7:0] CMD_PULSE = 8'hDA;
  localparam logic [7:0] RST_CONTRAST = 8'h7F;
  localparam logic [7:0] RST_MUX = 8'h5F;
  localparam logic [7:0] RST_CLK_DIV = 8'h80;
  localparam logic [4:0] RST_PRECHARGE = 5'h04;
  localparam logic [7:0] RST_PULSE = 8'h10;
  localparam logic [4:0] PRE_MIN = 5'h02;
  localparam logic [4:0] PRE_MAX = 5'h1E;
  localparam int unsigned COLS = 128;
  localparam int unsigned PAGES = 12;
  localparam int unsigned ROWS = 96;
  localparam logic [6:0] ROW_LAST = 7'h5F;
  localparam logic [6:0] COL_LAST = 7'h7F;
  typedef enum logic [1:0] {PH_DISCHARGE, PH_PRECHARGE, PH_DRIVE} phase_t;
endpackage : oled_core_pkg

// ---- pkg/oled_tick_if.sv ----
// display clock tick carrier between the core and its divider
`timescale 1ns/1ns
`default_nettype none
interface oled_tick_if;
  logic [3:0] div_m1;
  logic [3:0] osc_freq;
  logic use_int_osc;
  logic tick;
  modport core (output div_m1, output osc_freq, output use_int_osc, input tick);
  modport gen (input div_m1, input osc_freq, input use_int_osc, output tick);
endinterface : oled_tick_if
`default_nettype wire

// ---- hdl/oled_clock_gen.sv ----
// operating clock source select and display clock divider
`timescale 1ns/1ns
`default_nettype none
module oled_clock_gen (
  input wire logic I_CLK_SYS,
  input wire logic I_SRST,
  input wire logic i_ext_clk_rise,
  oled_tick_if.gen tk
);
  // internal oscillator modelled as a phase accumulator; higher setting is faster
  logic [7:0] osc_acc_q;
  logic [8:0] osc_sum;
  logic osc_tick;
  logic src_tick;
  logic [3:0] div_cnt_q;

  assign osc_sum = {1'b0, osc_acc_q} + {4'h0, tk.osc_freq, 1'b0} + 9'h001;
  assign osc_tick = osc_sum[8];

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST || !tk.use_int_osc) begin
      osc_acc_q <= 8'h00;
    end else begin
      osc_acc_q <= osc_sum[7:0];
    end
  end

  assign src_tick = tk.use_int_osc ? osc_tick : i_ext_clk_rise;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      div_cnt_q <= 4'h0;
    end else if (src_tick) begin
      div_cnt_q <= (div_cnt_q >= tk.div_m1) ? 4'h0 : div_cnt_q + 4'h1;
    end
  end

  assign tk.tick = src_tick && (div_cnt_q >= tk.div_m1);
endmodule : oled_clock_gen
`default_nettype wire

// ---- hdl/oled_display_core.sv ----
// display core: command decode, display ram, row timing and output mapping
`timescale 1ns/1ns
`default_nettype none
// How it works
// - data/command high writes byte to ram, low decodes it as command
// - clock source pin high uses internal oscillator, low uses external clock
// - upper nibble of divide command sets oscillator speed, higher is faster
// - display clock is operating clock divided by one to sixteen
// - frame period is divide ratio times clocks per row times rows
// - multiplex ratio command, reset value 95 meaning 96 rows
// - reset: display off, normal mapping, normal scan, contrast 7Fh
// - reset clears serial shift, start line zero, column pointer zero
// - contrast 1 to 255 sets column current equal to contrast
// - each row: discharge, precharge 2 to 30 clocks, then drive
// - drive lasts N display clocks then next row discharges
// - ram is 128 by 96 bits, page p feeds rows 8p to 8p+7
// - data byte fills page column, bit 0 top row, bit 7 bottom
// - row remap reverses rows, column remap reverses column outputs
// - start line register selects ram row shown on first row
// - reference select bit: 0 external at reset, 1 internal while on
// - display on command activates outputs 40 ms later
// - display off command turns display off before supply removal
// - reset held at least 3 us, registers held in reset until it ends
// - column pointer increments after each data byte
module oled_display_core #(
  parameter int unsigned ON_DELAY = oled_core_pkg::ON_DELAY_CYC
) (
  input wire logic I_CLK_SYS,
  input wire logic I_SRST,
  input wire logic i_active_low_reset_pin_n,
  input wire logic i_clock_source_select,
  input wire logic i_external_clock_input,
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  input wire logic i_data_command_select,
  input wire logic [3:0] i_page_select,
  input wire logic i_serial_bit_valid,
  input wire logic i_serial_bit,
  output logic o_frame_sync_output,
  output logic o_display_on,
  output logic o_outputs_active,
  output logic o_iref_internal,
  output logic [1:0] o_phase,
  output logic [6:0] o_row_output,
  output logic [127:0] o_column_output,
  output logic [11:0] o_column_drive_current,
  output logic [7:0] o_serial_shift
);
  // pin level synchronisers
  logic [1:0] rst_sync_q;
  logic [1:0] cls_sync_q;
  logic [2:0] ext_sync_q;
  logic pin_reset;
  logic ext_rise;

  always_ff @(posedge I_CLK_SYS) begin
    rst_sync_q <= {rst_sync_q[0], i_active_low_reset_pin_n};
    cls_sync_q <= {cls_sync_q[0], i_clock_source_select};
    ext_sync_q <= {ext_sync_q[1:0], i_external_clock_input};
  end
  assign ext_rise = ext_sync_q[1] && !ext_sync_q[2];

  // reset pin must stay low for the minimum width before it counts
  logic [7:0] low_cnt_q;
  logic low_long_q;
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST || rst_sync_q[1]) begin
      low_cnt_q <= 8'h00;
    end else if (low_cnt_q != 8'(oled_core_pkg::RST_MIN_CYC)) begin
      low_cnt_q <= low_cnt_q + 8'h01;
    end
  end
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      low_long_q <= 1'b0;
    end else begin
      low_long_q <= !rst_sync_q[1] && (low_cnt_q == 8'(oled_core_pkg::RST_MIN_CYC));
    end
  end
  // registers held in reset while pin is low long enough, released as it ends
  assign pin_reset = I_SRST || low_long_q;

  logic rst;
  assign rst = pin_reset;

  // command decoder state
  logic [7:0] contrast_q;
  logic [6:0] mux_q;
  logic [7:0] clk_div_q;
  logic [4:0] pre_len_q;
  logic [7:0] pulse_q;
  logic [6:0] start_line_q;
  logic col_remap_q;
  logic row_remap_q;
  logic all_on_q;
  logic disp_on_q;
  logic iref_sel_q;
  logic [7:0] pending_q;
  logic arg_wait_q;
  logic [6:0] col_ptr_q;
  logic [7:0] shift_q;
  logic cmd_take;
  logic data_take;

  assign data_take = i_byte_valid && i_data_command_select;
  assign cmd_take = i_byte_valid && !i_data_command_select;

  always_ff @(posedge I_CLK_SYS) begin
    if (rst) begin
      pending_q <= 8'h00;
      arg_wait_q <= 1'b0;
    end else if (cmd_take) begin
      if (arg_wait_q) begin
        arg_wait_q <= 1'b0;
      end else begin
        pending_q <= i_byte;
        arg_wait_q <= (i_byte == oled_core_pkg::CMD_CONTRAST) ||
                      (i_byte == oled_core_pkg::CMD_MUX) ||
                      (i_byte == oled_core_pkg::CMD_IREF) ||
                      (i_byte == oled_core_pkg::CMD_START_LINE) ||
                      (i_byte == oled_core_pkg::CMD_CLK_DIV) ||
                      (i_byte == oled_core_pkg::CMD_PHASE) ||
                      (i_byte == oled_core_pkg::CMD_PULSE);
      end
    end
  end

  logic arg_take;
  logic op_take;
  assign arg_take = cmd_take && arg_wait_q;
  assign op_take = cmd_take && !arg_wait_q;

  always_ff @(posedge I_CLK_SYS) begin
    if (rst) begin
      contrast_q <= oled_core_pkg::RST_CONTRAST;
      mux_q <= oled_core_pkg::RST_MUX[6:0];
      clk_div_q <= oled_core_pkg::RST_CLK_DIV;
      pre_len_q <= oled_core_pkg::RST_PRECHARGE;
      pulse_q <= oled_core_pkg::RST_PULSE;
      start_line_q <= 7'h00;
      iref_sel_q <= 1'b0;
    end else if (arg_take) begin
      unique case (pending_q)
        oled_core_pkg::CMD_CONTRAST: contrast_q <= i_byte;
        oled_core_pkg::CMD_MUX: begin
          // values beyond the panel height are clamped to 96 rows
          mux_q <= (i_byte[6:0] > oled_core_pkg::ROW_LAST) ?
                   oled_core_pkg::ROW_LAST : i_byte[6:0];
        end
        oled_core_pkg::CMD_IREF: iref_sel_q <= i_byte[4];
        oled_core_pkg::CMD_START_LINE: begin
          start_line_q <= (i_byte[6:0] > oled_core_pkg::ROW_LAST) ?
                          7'h00 : i_byte[6:0];
        end
        oled_core_pkg::CMD_CLK_DIV: clk_div_q <= i_byte;
        oled_core_pkg::CMD_PHASE: begin
          if (i_byte[4:0] < oled_core_pkg::PRE_MIN) begin
            pre_len_q <= oled_core_pkg::PRE_MIN;
          end else if (i_byte[4:0] > oled_core_pkg::PRE_MAX) begin
            pre_len_q <= oled_core_pkg::PRE_MAX;
          end else begin
            pre_len_q <= i_byte[4:0];
          end
        end
        oled_core_pkg::CMD_PULSE: pulse_q <= (i_byte == 8'h00) ? 8'h01 : i_byte;
        default: ;
      endcase
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (rst) begin
      col_remap_q <= 1'b0;
      row_remap_q <= 1'b0;
      all_on_q <= 1'b0;
      disp_on_q <= 1'b0;
    end else if (op_take) begin
      unique case (i_byte)
        oled_core_pkg::CMD_SEG_NORMAL: col_remap_q <= 1'b0;
        oled_core_pkg::CMD_SEG_REMAP: col_remap_q <= 1'b1;
        oled_core_pkg::CMD_SCAN_NORMAL: row_remap_q <= 1'b0;
        oled_core_pkg::CMD_SCAN_REMAP: row_remap_q <= 1'b1;
        oled_core_pkg::CMD_ALL_NORMAL: all_on_q <= 1'b0;
        oled_core_pkg::CMD_ALL_ON: all_on_q <= 1'b1;
        oled_core_pkg::CMD_DISP_ON: disp_on_q <= 1'b1;
        oled_core_pkg::CMD_DISP_OFF: disp_on_q <= 1'b0;
        default: ;
      endcase
    end
  end

  // serial shift register, cleared by reset
  always_ff @(posedge I_CLK_SYS) begin
    if (rst) begin
      shift_q <= 8'h00;
    end else if (i_serial_bit_valid) begin
      shift_q <= {shift_q[6:0], i_serial_bit};
    end
  end

  // display ram: one byte per page column
  logic [7:0] ram_q [oled_core_pkg::PAGES * oled_core_pkg::COLS];
  logic [3:0] wr_page;
  assign wr_page = (i_page_select > 4'(oled_core_pkg::PAGES - 1)) ?
                   4'(oled_core_pkg::PAGES - 1) : i_page_select;

  function automatic logic [10:0] ram_addr(input logic [3:0] page, input logic [6:0] col);
    ram_addr = 11'({page, 7'h00}) + 11'({4'h0, col});
  endfunction : ram_addr

  always_ff @(posedge I_CLK_SYS) begin
    if (data_take) begin
      ram_q[ram_addr(wr_page, col_ptr_q)] <= i_byte;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (rst) begin
      col_ptr_q <= 7'h00;
    end else if (data_take) begin
      col_ptr_q <= col_ptr_q + 7'h01;
    end
  end

  // clock source and divider
  oled_tick_if tk ();
  assign tk.div_m1 = clk_div_q[3:0];
  assign tk.osc_freq = clk_div_q[7:4];
  assign tk.use_int_osc = cls_sync_q[1];

  oled_clock_gen u_clock_gen (
    .I_CLK_SYS(I_CLK_SYS),
    .I_SRST(rst),
    .i_ext_clk_rise(ext_rise),
    .tk(tk)
  );

  // row phase sequencer
  oled_core_pkg::phase_t phase_q;
  logic [7:0] ph_cnt_q;
  logic [6:0] row_q;
  logic row_done;
  assign row_done = tk.tick && (phase_q == oled_core_pkg::PH_DRIVE) &&
                    (ph_cnt_q + 8'h01 >= pulse_q);

  always_ff @(posedge I_CLK_SYS) begin
    if (rst) begin
      phase_q <= oled_core_pkg::PH_DISCHARGE;
      ph_cnt_q <= 8'h00;
    end else if (tk.tick) begin
      unique case (phase_q)
        oled_core_pkg::PH_DISCHARGE: begin
          phase_q <= oled_core_pkg::PH_PRECHARGE;
          ph_cnt_q <= 8'h00;
        end
        oled_core_pkg::PH_PRECHARGE: begin
          if (ph_cnt_q + 8'h01 >= {3'h0, pre_len_q}) begin
            phase_q <= oled_core_pkg::PH_DRIVE;
            ph_cnt_q <= 8'h00;
          end else begin
            ph_cnt_q <= ph_cnt_q + 8'h01;
          end
        end
        oled_core_pkg::PH_DRIVE: begin
          if (ph_cnt_q + 8'h01 >= pulse_q) begin
            phase_q <= oled_core_pkg::PH_DISCHARGE;
            ph_cnt_q <= 8'h00;
          end else begin
            ph_cnt_q <= ph_cnt_q + 8'h01;
          end
        end
        default: begin
          phase_q <= oled_core_pkg::PH_DISCHARGE;
          ph_cnt_q <= 8'h00;
        end
      endcase
    end
  end

  // frame length follows the multiplex ratio, so frame rate scales as
  always_ff @(posedge I_CLK_SYS) begin
    if (rst) begin
      row_q <= 7'h00;
    end else if (row_done) begin
      row_q <= (row_q >= mux_q) ? 7'h00 : row_q + 7'h01;
    end
  end

  // sync pulse covers the first row of every frame; the host paces off its edges
  always_ff @(posedge I_CLK_SYS) begin
    if (rst) begin
      o_frame_sync_output <= 1'b0;
    end else begin
      o_frame_sync_output <= (row_q == 7'h00);
    end
  end

  // display-on delay before outputs go live
  logic [21:0] on_cnt_q;
  logic active_q;
  always_ff @(posedge I_CLK_SYS) begin
    if (rst || !disp_on_q) begin
      on_cnt_q <= 22'h00_0000;
      active_q <= 1'b0;
    end else if (on_cnt_q + 22'h00_0001 >= 22'(ON_DELAY)) begin
      active_q <= 1'b1;
    end else begin
      on_cnt_q <= on_cnt_q + 22'h00_0001;
    end
  end

  // row to ram mapping with start line and row remap
  logic [6:0] disp_row;
  logic [6:0] ram_row;
  logic [7:0] row_sum;
  always_comb begin
    disp_row = row_remap_q ? (oled_core_pkg::ROW_LAST - row_q) : row_q;
    row_sum = {1'b0, row_q} + {1'b0, start_line_q};
    ram_row = (row_sum > {1'b0, oled_core_pkg::ROW_LAST}) ?
              7'(row_sum - 8'(oled_core_pkg::ROWS)) : row_sum[6:0];
  end

  logic [127:0] cols_d;
  always_comb begin
    for (int c = 0; c < oled_core_pkg::COLS; c++) begin
      logic [7:0] b;
      logic [6:0] src;
      b = 8'h00;
      src = 7'h00;
      src = col_remap_q ? 7'(oled_core_pkg::COL_LAST - 7'(c)) : 7'(c);
      b = ram_q[ram_addr(ram_row[6:3], src)];
      cols_d[c] = all_on_q | b[ram_row[2:0]];
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (rst) begin
      o_column_output <= '0;
      o_row_output <= 7'h00;
      o_phase <= 2'h0;
      o_column_drive_current <= 12'h000;
    end else begin
      o_column_output <= (active_q && phase_q == oled_core_pkg::PH_DRIVE) ? cols_d : '0;
      o_row_output <= disp_row;
      o_phase <= phase_q;
      o_column_drive_current <= active_q ? {1'b0, contrast_q, 3'h0} >> 3 : 12'h000;
    end
  end

  assign o_display_on = disp_on_q;
  assign o_outputs_active = active_q;
  assign o_iref_internal = iref_sel_q && disp_on_q;
  assign o_serial_shift = shift_q;
endmodule : oled_display_core
`default_nettype wire

// ---- dv/oled_display_core_properties.sv ----
// port level assertions for the display timing core
`timescale 1ns/1ns
`default_nettype none
module oled_display_core_properties #(
  parameter int unsigned ON_DELAY = 20
) (
  input wire logic I_CLK_SYS,
  input wire logic I_SRST,
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  input wire logic i_data_command_select,
  input wire logic i_serial_bit_valid,
  input wire logic i_serial_bit,
  input wire logic o_frame_sync_output,
  input wire logic o_display_on,
  input wire logic o_outputs_active,
  input wire logic o_iref_internal,
  input wire logic [1:0] o_phase,
  input wire logic [6:0] o_row_output,
  input wire logic [127:0] o_column_output,
  input wire logic [11:0] o_column_drive_current,
  input wire logic [7:0] o_serial_shift
);
  int unsigned on_cnt_q;
  logic cmd;
  assign cmd = i_byte_valid && !i_data_command_select;
  // saturates so a long on time cannot wrap the turn-on window
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST || !o_display_on) begin
      on_cnt_q <= 0;
    end else if (on_cnt_q < ON_DELAY + 8) begin
      on_cnt_q <= on_cnt_q + 1;
    end
  end
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SRST);
  a_disp_on_cmd: assert property (cmd && i_byte == 8'hAF |-> ##[1:2] o_display_on)
    else $error("display on command ignored");
  a_disp_off_cmd: assert property (cmd && i_byte == 8'hAE |-> ##[1:2] !o_display_on)
    else $error("display off command ignored");
  a_reset_clear: assert property ($fell(I_SRST) |-> !o_display_on && !o_outputs_active
    && o_serial_shift == 8'h00 && o_column_drive_current == 12'h000)
    else $error("outputs not cleared by reset");
  a_active_delay: assert property ($rose(o_outputs_active)
    |-> on_cnt_q >= ON_DELAY - 2 && on_cnt_q <= ON_DELAY + 2)
    else $error("outputs activated at wrong time");
  a_iref_off: assert property (!o_display_on && !$past(o_display_on) |-> !o_iref_internal)
    else $error("internal reference while display off");
  a_current_idle: assert property (!o_outputs_active && !$past(o_outputs_active)
    |-> o_column_drive_current == 12'h000)
    else $error("column current while inactive");
  a_cols_dark: assert property (o_phase != 2'h2 && $past(o_phase) != 2'h2
    |-> o_column_output == 128'h0)
    else $error("columns driven outside drive phase");
  a_phase_order: assert property ($changed(o_phase) |-> o_phase == 2'h0
    || (o_phase == $past(o_phase) + 2'h1 && o_phase != 2'h3))
    else $error("phase sequence broken");
  a_sync_row0: assert property ($rose(o_frame_sync_output)
    |-> o_row_output == 7'h00 || o_row_output == 7'h5F)
    else $error("frame sync away from first row");
  a_serial_in: assert property (i_serial_bit_valid |=> o_serial_shift[0] == $past(i_serial_bit))
    else $error("serial bit not shifted in");
endmodule : oled_display_core_properties
bind oled_display_core oled_display_core_properties #(.ON_DELAY(ON_DELAY)) chk_u (
  .I_CLK_SYS(I_CLK_SYS),
  .I_SRST(I_SRST),
  .i_byte_valid(i_byte_valid),
  .i_byte(i_byte),
  .i_data_command_select(i_data_command_select),
  .i_serial_bit_valid(i_serial_bit_valid),
  .i_serial_bit(i_serial_bit),
  .o_frame_sync_output(o_frame_sync_output),
  .o_display_on(o_display_on),
  .o_outputs_active(o_outputs_active),
  .o_iref_internal(o_iref_internal),
  .o_phase(o_phase),
  .o_row_output(o_row_output),
  .o_column_output(o_column_output),
  .o_column_drive_current(o_column_drive_current),
  .o_serial_shift(o_serial_shift)
);
`default_nettype wire

// ---- dv/oled_host_model.sv ----
// host side model driving bytes, serial bits and pins of the core
`timescale 1ns/1ns
`default_nettype none
module oled_host_model (
  input wire logic i_clk,
  input wire logic i_frame_sync,
  output logic o_reset_pin_n,
  output logic o_clock_source_select,
  output logic o_external_clock,
  output logic o_byte_valid,
  output logic [7:0] o_byte,
  output logic o_dc,
  output logic o_serial_bit_valid,
  output logic o_serial_bit
);
  initial begin
    o_reset_pin_n = 1'b1;
    o_clock_source_select = 1'b1;
    o_external_clock = 1'b0;
    o_byte_valid = 1'b0;
    o_byte = 8'h00;
    o_dc = 1'b0;
    o_serial_bit_valid = 1'b0;
    o_serial_bit = 1'b0;
  end
  // clock pin held low while the internal oscillator is chosen
  always @(posedge i_clk) begin
    o_external_clock <= o_clock_source_select ? 1'b0 : ~o_external_clock;
  end
  task automatic set_src(input logic s);
    @(posedge i_clk);
    o_clock_source_select <= s;
  endtask : set_src
  task automatic send(input logic dc, input logic [7:0] b);
    @(posedge i_clk);
    o_byte_valid <= 1'b1;
    o_byte <= b;
    o_dc <= dc;
    @(posedge i_clk);
    o_byte_valid <= 1'b0;
    // idle bus never shows the stale byte
    o_byte <= ~b;
    o_dc <= ~dc;
  endtask : send
  task automatic cmd2(input logic [7:0] op, input logic [7:0] arg);
    send(1'b0, op);
    send(1'b0, arg);
  endtask : cmd2
  task automatic shift(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(posedge i_clk);
      o_serial_bit_valid <= 1'b1;
      o_serial_bit <= b[i];
    end
    @(posedge i_clk);
    o_serial_bit_valid <= 1'b0;
    o_serial_bit <= ~b[0];
  endtask : shift
  task automatic pin_reset;
    @(posedge i_clk);
    o_reset_pin_n <= 1'b0;
    repeat (oled_core_pkg::RST_MIN_CYC + 10) @(posedge i_clk);
    o_reset_pin_n <= 1'b1;
  endtask : pin_reset
  task automatic wait_rise;
    for (int k = 0; k < 100000 && i_frame_sync !== 1'b0; k++) @(posedge i_clk);
    for (int k = 0; k < 100000 && i_frame_sync !== 1'b1; k++) @(posedge i_clk);
  endtask : wait_rise
  task automatic wait_fall;
    wait_rise();
    for (int k = 0; k < 100000 && i_frame_sync !== 1'b0; k++) @(posedge i_clk);
  endtask : wait_fall
  task automatic sync_write(input logic [7:0] b0, input logic [7:0] b1);
    wait_rise();
    send(1'b1, b0);
    send(1'b1, b1);
  endtask : sync_write
endmodule : oled_host_model
`default_nettype wire

// ---- dv/oled_display_core_tb.sv ----
// self checking testbench for the display timing core
`timescale 1ns/1ns
`default_nettype none
module oled_display_core_tb;
  localparam int unsigned ON_DLY = 20;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic page = 1'b0;
  logic rst_n, clock_source_select, ext, bv, dc, sbv, sb, sync, on, act, iref;
  logic [7:0] bt, shf;
  logic [1:0] phase;
  logic [6:0] row;
  logic [127:0] cols;
  logic [11:0] cur;
  int n_mismatch = 0;
  int num_checks = 0;
  int f1, f2, f3;
  always #25 clk = ~clk;
  oled_host_model host_u (.i_clk(clk), .i_frame_sync(sync), .o_reset_pin_n(rst_n),
    .o_clock_source_select(clock_source_select), .o_external_clock(ext), .o_byte_valid(bv), .o_byte(bt),
    .o_dc(dc), .o_serial_bit_valid(sbv), .o_serial_bit(sb));
  oled_display_core #(.ON_DELAY(ON_DLY)) dut_u (.I_CLK_SYS(clk), .I_SRST(srst),
    .i_active_low_reset_pin_n(rst_n), .i_clock_source_select(clock_source_select),
    .i_external_clock_input(ext), .i_byte_valid(bv), .i_byte(bt), .i_data_command_select(dc),
    .i_page_select({3'h0, page}), .i_serial_bit_valid(sbv), .i_serial_bit(sb),
    .o_frame_sync_output(sync), .o_display_on(on), .o_outputs_active(act),
    .o_iref_internal(iref), .o_phase(phase), .o_row_output(row), .o_column_output(cols),
    .o_column_drive_current(cur), .o_serial_shift(shf));
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic frame_len(output int n);
    host_u.wait_rise();
    n = 0;
    while (sync !== 1'b0 && n < 100000) begin @(posedge clk); n++; end
    while (sync !== 1'b1 && n < 100000) begin @(posedge clk); n++; end
  endtask : frame_len
  // column levels are read a little into the drive phase, after they settle
  task automatic wait_drive(input logic [6:0] r);
    for (int k = 0; k < 50000 && !(row === r && phase === 2'h2); k++) begin
      @(posedge clk);
      #1;
    end
    tick(2);
  endtask : wait_drive
  initial begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    $display("watchdog expired");
    test_done();
  end
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    tick(2);
    check(128'(on), 128'h0);
    check(128'(cur), 128'h0);
    check(128'(iref), 128'h0);
    host_u.shift(8'hA5);
    tick(2);
    check(128'(shf), 128'hA5);
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    tick(2);
    check(128'(shf), 128'h0);
    $display("test reset done");
    host_u.set_src(1'b0);
    host_u.cmd2(8'hA8, 8'h0F);
    frame_len(f1);
    host_u.cmd2(8'hA8, 8'h07);
    frame_len(f2);
    check(128'(f1), 128'(2 * f2));
    host_u.cmd2(8'hD9, 8'h02);
    host_u.cmd2(8'hDA, 8'h06);
    frame_len(f3);
    // eight rows of one discharge, two precharge and six drive ticks, two cycles each
    check(128'(f3), 128'(8 * 9 * 2));
    host_u.cmd2(8'hD9, 8'h04);
    host_u.cmd2(8'hDA, 8'h10);
    host_u.cmd2(8'hD5, 8'h81);
    frame_len(f3);
    check(128'(f3), 128'(2 * f2));
    host_u.cmd2(8'hD5, 8'h70);
    host_u.set_src(1'b1);
    frame_len(f1);
    host_u.cmd2(8'hD5, 8'hF0);
    frame_len(f2);
    check(128'(f2 < f1), 128'h1);
    $display("test frame timing done");
    host_u.set_src(1'b0);
    host_u.cmd2(8'hD5, 8'h80);
    host_u.send(1'b0, 8'hAF);
    tick(2);
    check(128'(on), 128'h1);
    tick(ON_DLY + 3);
    check(128'(act), 128'h1);
    check(128'(cur), 128'h7F);
    host_u.cmd2(8'h81, 8'hC3);
    tick(3);
    check(128'(cur), 128'hC3);
    // ram powers up unknown, so page 0 is cleared before its columns are compared
    host_u.wait_fall();
    for (int i = 0; i < 128; i++) begin
      host_u.send(1'b1, 8'h00);
    end
    host_u.sync_write(8'h01, 8'h02);
    wait_drive(7'h00);
    check(128'(cols[1:0]), 128'h1);
    wait_drive(7'h01);
    check(128'(cols[1:0]), 128'h2);
    host_u.cmd2(8'hD3, 8'h01);
    wait_drive(7'h00);
    check(128'(cols[1:0]), 128'h2);
    @(posedge clk);
    page <= 1'b1;
    host_u.send(1'b1, 8'h01);
    host_u.cmd2(8'hD3, 8'h08);
    wait_drive(7'h00);
    check(128'(cols[2]), 128'h1);
    host_u.cmd2(8'hD3, 8'h00);
    host_u.send(1'b0, 8'hA1);
    wait_drive(7'h00);
    check(128'(cols[127:126]), 128'h2);
    host_u.send(1'b0, 8'hA0);
    host_u.send(1'b0, 8'hA5);
    wait_drive(7'h03);
    check(cols, {128{1'b1}});
    host_u.send(1'b0, 8'hA4);
    wait_drive(7'h03);
    check(cols, 128'h0);
    host_u.send(1'b0, 8'hC8);
    tick(3);
    check(128'(row >= 7'h58), 128'h1);
    host_u.send(1'b0, 8'hC0);
    host_u.cmd2(8'hAD, 8'h10);
    tick(3);
    check(128'(iref), 128'h1);
    host_u.send(1'b0, 8'hAE);
    tick(3);
    check(128'(on), 128'h0);
    check(128'(iref), 128'h0);
    $display("test display path done");
    host_u.shift(8'h3C);
    host_u.send(1'b0, 8'hAF);
    host_u.pin_reset();
    tick(6);
    check(128'(shf), 128'h0);
    check(128'(on), 128'h0);
    host_u.send(1'b0, 8'hAF);
    tick(ON_DLY + 5);
    check(128'(cur), 128'h7F);
    $display("test pin reset done");
    test_done();
  end
endmodule : oled_display_core_tb
`default_nettype wire
